// ===== hw/tkscn_params.svh
// constants of the touch-key scan-mode controller
`ifndef TKSCN_PARAMS_SVH
`define TKSCN_PARAMS_SVH
`define TKSCN_KEYS 16
`define TKSCN_KEY_W 4
`define TKSCN_TOUCH_THRESHOLD_LEVEL_W 3
`define TKSCN_TOUCH_THRESHOLD_LEVEL_MAX 3'h7
`define TKSCN_TOUCH_THRESHOLD_LEVEL_RST 3'h4
`define TKSCN_SLOW_DIV 4
`define TKSCN_PHASE_W 2
`define TKSCN_GREEN_MIN 8
`define TKSCN_THRESHOLD_RESISTOR_PAD_WAIT 8
`define TKSCN_THRESHOLD_RESISTOR_PAD_CNT_W 4
`define TKSCN_ADDR_W 5
`define TKSCN_OFF_CTRL 5'h00
`define TKSCN_OFF_LEVEL 5'h04
`define TKSCN_OFF_STATUS 5'h08
`define TKSCN_OFF_KEYS 5'h0C
`define TKSCN_OFF_IRQ_STAT 5'h10
`define TKSCN_OFF_IRQ_MASK 5'h14
`define TKSCN_CTRL_EN 0
`define TKSCN_CTRL_SLOW 1
`define TKSCN_STAT_MODE_LO 0
`define TKSCN_STAT_MODE_W 2
`define TKSCN_STAT_ANTI 2
`define TKSCN_STAT_THRESHOLD_RESISTOR_PAD_RDY 3
`define TKSCN_STAT_THRESHOLD_RESISTOR_PAD_LO 4
`define TKSCN_IRQ_WAKE 0
`define TKSCN_IRQ_KEY 1
`define TKSCN_IRQ_W 2
`define TKSCN_DEF_KEY_CFG 16'hFFFF
`define TKSCN_DEF_GROUP_SHIFT 2
`define TKSCN_FIRST_KEY 0
`endif

// ===== hw/tkscn_pkg.sv
// types of the touch-key scan-mode controller
package tkscn_pkg;
   typedef enum logic [1:0] {TKSCN_NORMAL, TKSCN_SLOW, TKSCN_GREEN} tkscn_mode_e;
   typedef enum logic [1:0] {TKSCN_HYST_OFF, TKSCN_HYST_SMALL, TKSCN_HYST_LARGE} tkscn_hyst_e;
endpackage

// ===== hw/tkscn_scan_sched.sv
// frame phase counter and per-key scan selection
`timescale 1ns/1ps
`include "tkscn_params.svh"
module tkscn_scan_sched #(
   parameter int GROUP_SHIFT = `TKSCN_DEF_GROUP_SHIFT
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic frame_tick_in,
   input wire logic run_in,
   input wire tkscn_pkg::tkscn_mode_e mode_in,
   input wire logic [`TKSCN_KEYS-1:0] key_cfg_in,
   output logic [`TKSCN_KEYS-1:0] scan_keys_out
);
   logic [`TKSCN_PHASE_W-1:0] phase_ff;
   logic [`TKSCN_PHASE_W-1:0] nxt_phase;
   logic [`TKSCN_KEYS-1:0] scan_keys_ff;
   logic [`TKSCN_KEYS-1:0] nxt_scan_keys;
   logic [`TKSCN_KEYS-1:0] slot_hit;

   // slot of each key within the four-frame cycle
   for (genvar i = 0; i < `TKSCN_KEYS; i++)
   begin : g_slot
      localparam logic [`TKSCN_PHASE_W-1:0] SLOT_SLOW = (`TKSCN_PHASE_W)'(i % `TKSCN_SLOW_DIV);
      localparam logic [`TKSCN_PHASE_W-1:0] SLOT_GRN =
         (`TKSCN_PHASE_W)'((i >> GROUP_SHIFT) % `TKSCN_SLOW_DIV);
      assign slot_hit[i] = (mode_in == tkscn_pkg::TKSCN_NORMAL) ||
                           ((mode_in == tkscn_pkg::TKSCN_SLOW) && (phase_ff == SLOT_SLOW)) ||
                           ((mode_in == tkscn_pkg::TKSCN_GREEN) && (phase_ff == SLOT_GRN));
   end

   always_comb
   begin
      nxt_phase = phase_ff;
      if (!run_in)
         nxt_phase = '0;
      else if (frame_tick_in)
         nxt_phase = phase_ff + (`TKSCN_PHASE_W)'(1);
      nxt_scan_keys = run_in ? (slot_hit & key_cfg_in) : '0;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         phase_ff <= '0;
         scan_keys_ff <= '0;
      end
      else
      begin
         phase_ff <= nxt_phase;
         scan_keys_ff <= nxt_scan_keys;
      end
   end

   assign scan_keys_out = scan_keys_ff;
endmodule

// ===== hw/tkscn_hyst.sv
// effective detection threshold with hysteresis applied
`timescale 1ns/1ps
`include "tkscn_params.svh"
module tkscn_hyst (
   input wire logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] level_in,
   input wire tkscn_pkg::tkscn_hyst_e hyst_in,
   input wire logic any_pressed_in,
   output logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] level_out,
   output logic halve_out
);
   always_comb
   begin
      level_out = level_in;
      halve_out = 1'b0;
      if (any_pressed_in)
      begin
         unique case (hyst_in)
            tkscn_pkg::TKSCN_HYST_SMALL:
            begin
               // saturate at the least sensitive code
               if (level_in != `TKSCN_TOUCH_THRESHOLD_LEVEL_MAX)
                  level_out = level_in + (`TKSCN_TOUCH_THRESHOLD_LEVEL_W)'(1);
            end
            tkscn_pkg::TKSCN_HYST_LARGE:
               halve_out = 1'b1;
            default:
               level_out = level_in;
         endcase
      end
   end
endmodule

// ===== hw/tkscn_ctrl.sv
// touch-key scan mode, wake-up, reporting and register block
// Functional notes
// - normal scanning by default; slow scan when software writes slow-scan select 1
// - slow mode scans each key once every four frames
// - confirmed press in slow modes returns to normal, hardware clears slow select
// - up to 16 keys, fixed by build-time key configuration mask
// - over 8 keys with green option: slow select enters slow-green mode
// - normal mode scans every configured key each frame
// - slow-green scans groups of 2 or 4 keys, each group every 4 frames
// - unconfirmed touch leaves slow mode and slow select unchanged
// - build option: wake by any key or only the first touch key
// - build option: single-key or multi-key reporting
// - 3-bit threshold level, 000 most sensitive, 111 least
// - build option enables anti-coupling between neighbouring keys
// - hysteresis while pressed: one level less sensitive, or halved threshold
// - touch function runs only while touch enable bit is 1
`timescale 1ns/1ps
`include "tkscn_params.svh"
module tkscn_ctrl #(
   parameter logic [`TKSCN_KEYS-1:0] KEY_CFG = `TKSCN_DEF_KEY_CFG,
   parameter bit GREEN_OPT = 1'b0,
   parameter int GROUP_SHIFT = `TKSCN_DEF_GROUP_SHIFT,
   parameter bit WAKE_FIRST_ONLY = 1'b0,
   parameter bit SINGLE_KEY = 1'b0,
   parameter bit ANTI_COUPLING = 1'b0,
   parameter tkscn_pkg::tkscn_hyst_e HYST = tkscn_pkg::TKSCN_HYST_OFF
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [`TKSCN_ADDR_W-1:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic frame_tick_in,
   input wire logic [`TKSCN_KEYS-1:0] key_press_in,
   input wire logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] threshold_resistor_code_in,
   output logic [`TKSCN_KEYS-1:0] scan_keys_out,
   output logic [1:0] scan_mode_out,
   output logic touch_run_out,
   output logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] threshold_level_out,
   output logic threshold_halve_out,
   output logic anti_coupling_out,
   output logic [`TKSCN_KEYS-1:0] key_state_out,
   output logic irq_out
);
   localparam int CFG_KEYS = $countones(KEY_CFG);
   localparam bit GREEN_OK = GREEN_OPT && (CFG_KEYS > `TKSCN_GREEN_MIN);

   // bus slave state
   logic waitreq_ff;
   logic nxt_waitreq;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_go;
   logic wr_lane0;

   // control and mode state
   logic touch_enable_bit_ff;
   logic nxt_touch_enable_bit;
   logic slow_scan_select_ff;
   logic nxt_slow_scan_select;
   logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] touch_threshold_level_ff;
   logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] nxt_touch_threshold_level;
   tkscn_pkg::tkscn_mode_e mode_ff;
   tkscn_pkg::tkscn_mode_e nxt_mode;

   // key reporting state
   logic [`TKSCN_KEYS-1:0] key_state_ff;
   logic [`TKSCN_KEYS-1:0] nxt_key_state;
   logic [`TKSCN_KEYS-1:0] press_cfg;
   logic [`TKSCN_KEYS-1:0] lowest_press;
   logic wake_hit;
   logic wake_evt;

   // threshold outputs
   logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] thr_level_ff;
   logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] thr_level_comb;
   logic thr_halve_ff;
   logic thr_halve_comb;

   // build option echoed on a pin
   logic anti_ff;
   logic nxt_anti;

   // resistor code capture after power-on
   logic [`TKSCN_THRESHOLD_RESISTOR_PAD_CNT_W-1:0] threshold_resistor_pad_cnt_ff;
   logic [`TKSCN_THRESHOLD_RESISTOR_PAD_CNT_W-1:0] nxt_threshold_resistor_pad_cnt;
   logic threshold_resistor_pad_rdy;
   logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] threshold_resistor_pad_code_ff;
   logic [`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] nxt_threshold_resistor_pad_code;

   // interrupts
   logic [`TKSCN_IRQ_W-1:0] irq_stat_ff;
   logic [`TKSCN_IRQ_W-1:0] nxt_irq_stat;
   logic [`TKSCN_IRQ_W-1:0] irq_mask_ff;
   logic [`TKSCN_IRQ_W-1:0] nxt_irq_mask;
   logic [`TKSCN_IRQ_W-1:0] irq_evt;
   logic irq_ff;
   logic nxt_irq;

   tkscn_scan_sched #(
      .GROUP_SHIFT(GROUP_SHIFT)
   ) u_sched (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .frame_tick_in(frame_tick_in),
      .run_in(touch_enable_bit_ff),
      .mode_in(mode_ff),
      .key_cfg_in(KEY_CFG),
      .scan_keys_out(scan_keys_out)
   );

   tkscn_hyst u_hyst (
      .level_in(touch_threshold_level_ff),
      .hyst_in(HYST),
      .any_pressed_in(|key_state_ff),
      .level_out(thr_level_comb),
      .halve_out(thr_halve_comb)
   );

   // bus slave: one wait cycle, then the access completes
   always_comb
   begin
      nxt_waitreq = 1'b1;
      nxt_rdata = rdata_ff;
      if ((read_in || write_in) && waitreq_ff)
      begin
         nxt_waitreq = 1'b0;
         nxt_rdata = '0;
         if (read_in)
         begin
            unique case (address_in)
               `TKSCN_OFF_CTRL:
               begin
                  nxt_rdata[`TKSCN_CTRL_EN] = touch_enable_bit_ff;
                  nxt_rdata[`TKSCN_CTRL_SLOW] = slow_scan_select_ff;
               end
               `TKSCN_OFF_LEVEL:
                  nxt_rdata[`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0] = touch_threshold_level_ff;
               `TKSCN_OFF_STATUS:
               begin
                  nxt_rdata[`TKSCN_STAT_MODE_LO +: `TKSCN_STAT_MODE_W] = mode_ff;
                  nxt_rdata[`TKSCN_STAT_ANTI] = ANTI_COUPLING;
                  nxt_rdata[`TKSCN_STAT_THRESHOLD_RESISTOR_PAD_RDY] = threshold_resistor_pad_rdy;
                  nxt_rdata[`TKSCN_STAT_THRESHOLD_RESISTOR_PAD_LO +: `TKSCN_TOUCH_THRESHOLD_LEVEL_W] = threshold_resistor_pad_code_ff;
               end
               `TKSCN_OFF_KEYS:
                  nxt_rdata[`TKSCN_KEYS-1:0] = key_state_ff;
               `TKSCN_OFF_IRQ_STAT:
                  nxt_rdata[`TKSCN_IRQ_W-1:0] = irq_stat_ff;
               `TKSCN_OFF_IRQ_MASK:
                  nxt_rdata[`TKSCN_IRQ_W-1:0] = irq_mask_ff;
               default:
                  nxt_rdata = '0;
            endcase
         end
      end
   end

   assign wr_go = write_in && !waitreq_ff;
   assign wr_lane0 = wr_go && byteenable_in[0];

   // keys pressed among the configured pins only
   assign press_cfg = touch_enable_bit_ff ? (key_press_in & KEY_CFG) : '0;
   assign lowest_press = press_cfg & (~press_cfg + (`TKSCN_KEYS)'(1));

   // a confirmed press wakes; optionally only the first touch key
   assign wake_hit = WAKE_FIRST_ONLY ? press_cfg[`TKSCN_FIRST_KEY] : (|press_cfg);

   // wake counts only while scanning slowly
   assign wake_evt = (mode_ff != tkscn_pkg::TKSCN_NORMAL) && wake_hit;

   // key reporting: single-key holds the first key until release
   always_comb
   begin
      nxt_key_state = press_cfg;
      if (SINGLE_KEY)
      begin
         if ((key_state_ff & press_cfg) != '0)
            nxt_key_state = key_state_ff & press_cfg;
         else
            nxt_key_state = lowest_press;
      end
   end

   // control register, slow select and threshold level
   always_comb
   begin
      nxt_touch_enable_bit = touch_enable_bit_ff;
      nxt_slow_scan_select = slow_scan_select_ff;
      nxt_touch_threshold_level = touch_threshold_level_ff;
      // a press confirmed while slow clears the select bit
      if (wake_evt)
         nxt_slow_scan_select = 1'b0;
      if (wr_lane0 && (address_in == `TKSCN_OFF_CTRL))
      begin
         nxt_touch_enable_bit = writedata_in[`TKSCN_CTRL_EN];
         nxt_slow_scan_select = writedata_in[`TKSCN_CTRL_SLOW];
      end
      if (wr_lane0 && (address_in == `TKSCN_OFF_LEVEL))
         nxt_touch_threshold_level = writedata_in[`TKSCN_TOUCH_THRESHOLD_LEVEL_W-1:0];
   end

   // scan mode follows the select bit; no press keeps it unchanged
   always_comb
   begin
      nxt_mode = tkscn_pkg::TKSCN_NORMAL;
      if (nxt_touch_enable_bit && nxt_slow_scan_select)
         nxt_mode = GREEN_OK ? tkscn_pkg::TKSCN_GREEN : tkscn_pkg::TKSCN_SLOW;
   end

   // resistor code becomes valid a fixed wait after reset
   always_comb
   begin
      nxt_threshold_resistor_pad_cnt = threshold_resistor_pad_cnt_ff;
      nxt_threshold_resistor_pad_code = threshold_resistor_pad_code_ff;
      if (!threshold_resistor_pad_rdy)
         nxt_threshold_resistor_pad_cnt = threshold_resistor_pad_cnt_ff + (`TKSCN_THRESHOLD_RESISTOR_PAD_CNT_W)'(1);
      else
         nxt_threshold_resistor_pad_code = threshold_resistor_code_in;
   end
   // ready once the power-on wait has run out
   assign threshold_resistor_pad_rdy = (threshold_resistor_pad_cnt_ff == (`TKSCN_THRESHOLD_RESISTOR_PAD_CNT_W)'(`TKSCN_THRESHOLD_RESISTOR_PAD_WAIT));

   // sticky events, write one to clear, set beats clear
   assign irq_evt[`TKSCN_IRQ_WAKE] = wake_evt;
   assign irq_evt[`TKSCN_IRQ_KEY] = (nxt_key_state != key_state_ff);
   always_comb
   begin
      nxt_irq_stat = irq_stat_ff;
      nxt_irq_mask = irq_mask_ff;
      if (wr_lane0 && (address_in == `TKSCN_OFF_IRQ_STAT))
         nxt_irq_stat = irq_stat_ff & ~writedata_in[`TKSCN_IRQ_W-1:0];
      if (wr_lane0 && (address_in == `TKSCN_OFF_IRQ_MASK))
         nxt_irq_mask = writedata_in[`TKSCN_IRQ_W-1:0];
      nxt_irq_stat = nxt_irq_stat | irq_evt;
      nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
   end

   // bus slave registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         waitreq_ff <= 1'b1;
         rdata_ff <= '0;
      end
      else
      begin
         waitreq_ff <= nxt_waitreq;
         rdata_ff <= nxt_rdata;
      end
   end

   // control and mode registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         touch_enable_bit_ff <= 1'b0;
         slow_scan_select_ff <= 1'b0;
         touch_threshold_level_ff <= `TKSCN_TOUCH_THRESHOLD_LEVEL_RST;
         mode_ff <= tkscn_pkg::TKSCN_NORMAL;
      end
      else
      begin
         touch_enable_bit_ff <= nxt_touch_enable_bit;
         slow_scan_select_ff <= nxt_slow_scan_select;
         touch_threshold_level_ff <= nxt_touch_threshold_level;
         mode_ff <= nxt_mode;
      end
   end

   // key state and threshold registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         key_state_ff <= '0;
         thr_level_ff <= `TKSCN_TOUCH_THRESHOLD_LEVEL_RST;
         thr_halve_ff <= 1'b0;
      end
      else
      begin
         key_state_ff <= nxt_key_state;
         thr_level_ff <= thr_level_comb;
         thr_halve_ff <= thr_halve_comb;
      end
   end

   // resistor code registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         threshold_resistor_pad_cnt_ff <= '0;
         threshold_resistor_pad_code_ff <= '0;
      end
      else
      begin
         threshold_resistor_pad_cnt_ff <= nxt_threshold_resistor_pad_cnt;
         threshold_resistor_pad_code_ff <= nxt_threshold_resistor_pad_code;
      end
   end

   // interrupt registers
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff <= nxt_irq;
      end
   end

   assign nxt_anti = ANTI_COUPLING;

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         anti_ff <= 1'b0;
      else
         anti_ff <= nxt_anti;
   end

   // all outputs come straight from registers
   assign readdata_out = rdata_ff;
   assign anti_coupling_out = anti_ff;
   assign waitrequest_out = waitreq_ff;
   assign scan_mode_out = mode_ff;
   assign touch_run_out = touch_enable_bit_ff;
   assign threshold_level_out = thr_level_ff;
   assign threshold_halve_out = thr_halve_ff;
   assign key_state_out = key_state_ff;
   assign irq_out = irq_ff;
endmodule

// ===== tb/tkscn_ctrl_sva.sv
// concurrent checks on the ports of the scan-mode controller
`timescale 1ns/1ps
`include "tkscn_params.svh"
module tkscn_ctrl_sva #(
   parameter logic [15:0] KEY_CFG = 16'hFFFF,
   parameter bit GREEN_OPT = 1'b0,
   parameter bit WAKE_FIRST_ONLY = 1'b0,
   parameter bit SINGLE_KEY = 1'b0,
   parameter tkscn_pkg::tkscn_hyst_e HYST = tkscn_pkg::TKSCN_HYST_OFF
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [4:0] address_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   input wire logic waitrequest_out,
   input wire logic [15:0] key_press_in,
   input wire logic [15:0] scan_keys_out,
   input wire logic [1:0] scan_mode_out,
   input wire logic touch_run_out,
   input wire logic [2:0] threshold_level_out,
   input wire logic threshold_halve_out,
   input wire logic [15:0] key_state_out
);
   localparam bit GREEN = GREEN_OPT && ($countones(KEY_CFG) > `TKSCN_GREEN_MIN);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   a_slow_entry: assert property (
      write_in && !waitrequest_out && address_in == `TKSCN_OFF_CTRL && byteenable_in[0]
      && writedata_in[1:0] == 2'h3 && key_press_in == 16'h0 |-> ##[1:2]
      scan_mode_out == (GREEN ? 2'h2 : 2'h1))
      else $error("slow select did not enter slow scan");
   a_slow_pattern: assert property (
      (scan_mode_out == 2'h1)[*2] |-> scan_keys_out inside {KEY_CFG & 16'h1111,
      KEY_CFG & 16'h2222, KEY_CFG & 16'h4444, KEY_CFG & 16'h8888})
      else $error("slow scan key set wrong");
   a_wake_normal: assert property (
      scan_mode_out != 2'h0 && touch_run_out && !write_in && (WAKE_FIRST_ONLY
      ? (key_press_in[0] && KEY_CFG[0]) : (|(key_press_in & KEY_CFG)))
      |-> ##[1:3] scan_mode_out == 2'h0)
      else $error("press did not return to normal scan");
   a_normal_all: assert property (
      (scan_mode_out == 2'h0 && touch_run_out)[*2] |-> scan_keys_out == KEY_CFG)
      else $error("normal scan misses keys");
   a_slow_stays: assert property (
      scan_mode_out == 2'h1 && !write_in && (key_press_in | $past(key_press_in)
      | $past(key_press_in, 2)) == 16'h0 |=> scan_mode_out == 2'h1)
      else $error("slow scan left without press");
   a_multi_report: assert property (
      !SINGLE_KEY && touch_run_out && $past(touch_run_out)
      |-> key_state_out == ($past(key_press_in) & KEY_CFG))
      else $error("reported keys differ from presses");
   a_hyst_step: assert property (
      HYST == tkscn_pkg::TKSCN_HYST_SMALL && $rose(|key_state_out) && !write_in
      && !$past(write_in) |=> threshold_level_out == (($past(threshold_level_out) == 3'h7)
      ? 3'h7 : $past(threshold_level_out) + 3'h1))
      else $error("small hysteresis level wrong");
   a_halve_held: assert property (
      threshold_halve_out |-> $past(key_state_out) != 16'h0)
      else $error("threshold halved with no key held");
   a_disabled_idle: assert property (
      (!touch_run_out)[*2] |-> key_state_out == 16'h0 && scan_mode_out == 2'h0)
      else $error("disabled touch still active");
   c_wake: cover property (scan_mode_out != 2'h0 ##1 scan_mode_out == 2'h0);
   c_slow: cover property ((scan_mode_out == 2'h1)[*8]);
   c_sat: cover property ($rose(|key_state_out) ##1 threshold_level_out == 3'h7);
   c_green: cover property (scan_mode_out == 2'h2 ##1 scan_mode_out == 2'h0);
endmodule
bind tkscn_ctrl tkscn_ctrl_sva #(.KEY_CFG(KEY_CFG), .GREEN_OPT(GREEN_OPT),
   .WAKE_FIRST_ONLY(WAKE_FIRST_ONLY), .SINGLE_KEY(SINGLE_KEY), .HYST(HYST))
   tkscn_ctrl_sva_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
   .address_in(address_in), .write_in(write_in), .writedata_in(writedata_in),
   .byteenable_in(byteenable_in), .waitrequest_out(waitrequest_out),
   .key_press_in(key_press_in), .scan_keys_out(scan_keys_out),
   .scan_mode_out(scan_mode_out), .touch_run_out(touch_run_out),
   .threshold_level_out(threshold_level_out), .threshold_halve_out(threshold_halve_out),
   .key_state_out(key_state_out));

// ===== tb/tkscn_pad_model.sv
// behavioural sensing front end: frame ticks, debounced presses, resistor code
`timescale 1ns/1ps
module tkscn_pad_model #(
   parameter int FRAME = 8
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [15:0] touch_in,
   input wire logic [2:0] resistor_in,
   output logic frame_tick_out,
   output logic [15:0] key_press_out,
   output logic [2:0] resistor_code_out
);
   int cnt;
   initial
   begin
      cnt = 0;
      frame_tick_out = 1'b0;
      key_press_out = 16'h0;
      resistor_code_out = 3'h0;
   end
   // sixteen pads, presses passed on already debounced
   always @(posedge clk_sys_in)
   begin
      cnt <= (reset_in || cnt == FRAME - 1) ? 0 : cnt + 1;
      frame_tick_out <= !reset_in && cnt == FRAME - 1;
      key_press_out <= reset_in ? 16'h0 : touch_in;
      resistor_code_out <= resistor_in;
   end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the touch-key scan-mode controller
`timescale 1ns/1ps
`include "tkscn_params.svh"
module testbench;
   logic clk_sys_in, reset_in, read_in, write_in, waitrequest_out, frame_tick_in;
   logic touch_run_out, irq_out;
   logic anti, halve, alt_halve, alt_anti;
   logic [15:0] alt_scan, alt_keys, seen_alt;
   logic [1:0] alt_mode;
   logic [4:0] address_in;
   logic [31:0] writedata_in, readdata_out, rd;
   logic [15:0] key_press_in, scan_keys_out, key_state_out, touch, seen;
   logic [2:0] code_in, code, level_out;
   logic [1:0] scan_mode_out;
   int n_errors = 0;
   int comparisons = 0;
   tkscn_ctrl #(.HYST(tkscn_pkg::TKSCN_HYST_SMALL)) tkscn_ctrl_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
      .byteenable_in(4'hF), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
      .frame_tick_in(frame_tick_in), .key_press_in(key_press_in),
      .threshold_resistor_code_in(code_in), .scan_keys_out(scan_keys_out),
      .scan_mode_out(scan_mode_out), .touch_run_out(touch_run_out),
      .threshold_level_out(level_out), .threshold_halve_out(halve), .anti_coupling_out(anti),
      .key_state_out(key_state_out), .irq_out(irq_out));
   tkscn_pad_model tkscn_pad_model_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .touch_in(touch), .resistor_in(code), .frame_tick_out(frame_tick_in),
      .key_press_out(key_press_in), .resistor_code_out(code_in));
   // second build: slow-green, first-key wake, single key, large hysteresis
   if (1)
   begin : g_alt
      tkscn_ctrl #(.GREEN_OPT(1'b1), .WAKE_FIRST_ONLY(1'b1), .SINGLE_KEY(1'b1),
         .ANTI_COUPLING(1'b1), .HYST(tkscn_pkg::TKSCN_HYST_LARGE)) tkscn_ctrl_inst (
         .clk_sys_in(clk_sys_in), .reset_in(reset_in), .address_in(address_in),
         .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
         .byteenable_in(4'hF), .readdata_out(), .waitrequest_out(),
         .frame_tick_in(frame_tick_in), .key_press_in(key_press_in),
         .threshold_resistor_code_in(code_in), .scan_keys_out(alt_scan),
         .scan_mode_out(alt_mode), .touch_run_out(), .threshold_level_out(),
         .threshold_halve_out(alt_halve), .anti_coupling_out(alt_anti),
         .key_state_out(alt_keys), .irq_out());
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      address_in <= a;
      writedata_in <= d;
      read_in <= !wr;
      write_in <= wr;
      // this wait ends once waitrequest_out drops to 0
      do
         @(posedge clk_sys_in);
      while (waitrequest_out !== 1'b0);
      rd = readdata_out;
      read_in <= 1'b0;
      write_in <= 1'b0;
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic frame;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (frame_tick_in !== 1'b1 && n < 64);
      cyc(3);
   endtask
   task automatic t_reset;
      rc(`TKSCN_OFF_CTRL, 32'h0, "ctrl");
      rc(`TKSCN_OFF_LEVEL, 32'h4, "level");
      rc(5'h18, 32'h0, "unmapped");
      rc(`TKSCN_OFF_IRQ_MASK, 32'h0, "mask");
      // resistor code valid once the power-on wait has passed
      rc(`TKSCN_OFF_STATUS, {25'h0, code, 4'h8}, "status");
      chk("anti", 0, anti);
      chk("alt anti", 1, alt_anti);
      $display("test reset done");
   endtask
   task automatic t_level;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, `TKSCN_OFF_LEVEL, 32'(i));
         rc(`TKSCN_OFF_LEVEL, 32'(i), "level rw");
      end
      bus(1'b1, `TKSCN_OFF_LEVEL, 32'h3);
      $display("test level done");
   endtask
   task automatic t_scan;
      bus(1'b1, `TKSCN_OFF_CTRL, 32'h1);
      frame;
      chk("run", 1, touch_run_out);
      chk("normal keys", 32'hFFFF, scan_keys_out);
      chk("alt normal keys", 32'hFFFF, alt_scan);
      bus(1'b1, `TKSCN_OFF_CTRL, 32'h3);
      seen = 16'h0;
      seen_alt = 16'h0;
      repeat (4)
      begin
         frame;
         chk("slow count", 4, 32'($countones(scan_keys_out)));
         seen = seen | scan_keys_out;
         chk("green group", 1, 32'(alt_scan inside {16'h000F, 16'h00F0, 16'h0F00, 16'hF000}));
         seen_alt = seen_alt | alt_scan;
      end
      chk("slow union", 32'hFFFF, seen);
      chk("green union", 32'hFFFF, seen_alt);
      chk("green mode", 2, alt_mode);
      chk("slow mode", 1, scan_mode_out);
      rc(`TKSCN_OFF_CTRL, 32'h3, "slow kept");
      $display("test scan done");
   endtask
   task automatic t_wake;
      bus(1'b1, `TKSCN_OFF_IRQ_MASK, 32'h1);
      touch <= 16'h0220;
      cyc(6);
      chk("wake mode", 0, scan_mode_out);
      chk("multi keys", 32'h0220, key_state_out);
      chk("held level", 4, level_out);
      chk("small no halve", 0, halve);
      chk("first-key only", 2, alt_mode);
      chk("single key", 32'h0020, alt_keys);
      chk("halve held", 1, alt_halve);
      chk("irq set", 1, irq_out);
      rc(`TKSCN_OFF_CTRL, 32'h1, "slow cleared");
      rc(`TKSCN_OFF_IRQ_STAT, 32'h3, "irq status");
      bus(1'b1, `TKSCN_OFF_IRQ_STAT, 32'h1);
      cyc(2);
      chk("irq masked", 0, irq_out);
      touch <= 16'h0;
      cyc(4);
      chk("released level", 3, level_out);
      chk("halve released", 0, alt_halve);
      bus(1'b1, `TKSCN_OFF_LEVEL, 32'h7);
      touch <= 16'h0001;
      cyc(4);
      chk("saturated level", 7, level_out);
      chk("first-key wake", 0, alt_mode);
      bus(1'b1, `TKSCN_OFF_CTRL, 32'h0);
      cyc(3);
      chk("off keys", 0, key_state_out);
      touch <= 16'h0;
      $display("test wake done");
   endtask
   task automatic results;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   initial
   begin
      reset_in = 1'b1;
      read_in = 1'b0;
      write_in = 1'b0;
      address_in = 5'h00;
      writedata_in = 32'h0;
      touch = 16'h0;
      code = 3'h5;
      cyc(6);
      reset_in <= 1'b0;
      t_reset;
      t_level;
      t_scan;
      t_wake;
      results;
   end
   initial
   begin
      cyc(5000);
      n_errors++;
      results;
   end
endmodule
